// [tma_defs.svh]
`ifndef TMA_DEFS_SVH
`define TMA_DEFS_SVH

// control register fields
`define TMA_CTRL_RESET   8'h00
`define TMA_CTRL_WMASK   8'hFB
`define TMA_BIT_OVF_EN   0
`define TMA_BIT_MC_EN    1
`define TMA_BIT_CLEAR    2
`define TMA_MODE_LSB     3
`define TMA_MODE_MSB     4
`define TMA_CLK_LSB      5
`define TMA_CLK_MSB      7

// pending register fields
`define TMA_PEND_RESET   2'h0
`define TMA_PEND_OVF     0
`define TMA_PEND_MC      1

// capture source select in the port control input
`define TMA_P1_CAPSEL    4

// vectors on the level zero request
`define TMA_VEC_OVF      8'hD0
`define TMA_VEC_MC       8'hCE

// counter limits
`define TMA_CNT_TOP      8'hFF
`define TMA_CNT_ZERO     8'h00
`define TMA_REF_RESET    8'h00

// prescaler masks for the divided rates
`define TMA_PRE_RESET    10'h000
`define TMA_PRE_1024     10'h3FF
`define TMA_PRE_256      10'h0FF
`define TMA_PRE_64       10'h03F
`define TMA_PRE_8        10'h007

`endif

// [tma_pkg.sv]
`default_nettype none
package tma_pkg;

  typedef enum logic [1:0] {
    TMA_INTERVAL = 2'h0,
    TMA_CAP_RISE = 2'h1,
    TMA_CAP_FALL = 2'h2,
    TMA_PWM      = 2'h3
  } tma_mode_e;

  typedef enum logic [2:0] {
    TMA_DIV1024  = 3'h0,
    TMA_DIV256   = 3'h1,
    TMA_DIV64    = 3'h2,
    TMA_DIV8     = 3'h3,
    TMA_DIV1     = 3'h4,
    TMA_EXT_FALL = 3'h5,
    TMA_EXT_RISE = 3'h6,
    TMA_STOP     = 3'h7
  } tma_clksel_e;

endpackage
`default_nettype wire

// [tma_edge_sync.sv]
`default_nettype none
module tma_edge_sync (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic sync;
  logic last;

  // meta feeds only sync; edges are seen from sync and last
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= din;
      sync <= meta;
      last <= sync;
    end
  end

  always_comb begin
    rise = sync & ~last;
    fall = ~sync & last;
  end
endmodule
`default_nettype wire

// [tma_timer.sv]
// How it works
// - overflow request goes out on level zero with vector D0h
// - overflow pending bit 0 clears on service or by writing 0
// - match/capture uses level zero, vector CEh, gated by control bit 1
// - match/capture pending bit 1 stays set until software writes 0
// - interval mode: counter equal to reference gives match, clears counter
// - interval mode: each match inverts the toggle output
// - pwm mode: counter runs free, FFh wraps to 00h, match no clear
// - pwm output low when reference <= counter, high when greater
// - pwm period is 256 timer clock ticks
// - capture edge of chosen polarity copies counter into reference
// - capture source is the pin when port control bit 4 is 0
// - capture mode requests overflow on wrap and match on each load
// - control bits 4:3 pick interval, capture rise, capture fall, pwm
// - control bits 7:5 pick divider, external edge or stop
// - writing 1 to control bit 2 clears the counter
// - control bit 0 enables overflow request; reset zeroes control
`default_nettype none
`include "tma_defs.svh"
module tma_timer (
  input  wire logic       CORE_CLK,
  input  wire logic       ARST_N,
  input  wire logic       CTRL_WR,
  input  wire logic [7:0] CTRL_WDATA,
  input  wire logic       REF_WR,
  input  wire logic [7:0] REF_WDATA,
  input  wire logic       PEND_WR,
  input  wire logic [1:0] PEND_WDATA,
  input  wire logic       OVF_ACK,
  input  wire logic [7:0] PORT_ONE_CONTROL_LOW,
  input  wire logic       CAPTURE_IN_PIN,
  input  wire logic       EXT_CLOCK_IN,
  output logic      [7:0] CTRL_RDATA,
  output logic      [7:0] REF_RDATA,
  output logic      [7:0] CNT_VALUE,
  output logic      [1:0] IRQ_PENDING,
  output logic            OVF_IRQ,
  output logic            MATCH_CAPTURE_IRQ,
  output logic            PRIORITY_LEVEL_ZERO,
  output logic      [7:0] IRQ_VECTOR,
  output logic            PWM_OUT_PIN,
  output logic            MATCH_TOGGLE_OUT
);
  logic [9:0] pre;
  logic [9:0] next_pre;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] refv;
  logic [7:0] next_refv;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [1:0] pend;
  logic [1:0] next_pend;
  logic       tog;
  logic       next_tog;
  logic       pwm;
  logic       next_pwm;
  logic       cap_rise;
  logic       cap_fall;
  logic       ext_rise;
  logic       ext_fall;
  logic       tick;
  logic       cap_edge;
  logic       clr_wr;
  logic       match;
  logic       ovf_set;
  logic       mc_set;
  tma_pkg::tma_mode_e   mode;
  tma_pkg::tma_mode_e   next_mode;
  tma_pkg::tma_clksel_e clksel;

  tma_edge_sync u_cap_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .din    (CAPTURE_IN_PIN),
    .rise   (cap_rise),
    .fall   (cap_fall)
  );

  tma_edge_sync u_ext_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .din    (EXT_CLOCK_IN),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  always_comb begin
    mode   = tma_pkg::tma_mode_e'(ctrl[`TMA_MODE_MSB:`TMA_MODE_LSB]);
    clksel = tma_pkg::tma_clksel_e'(ctrl[`TMA_CLK_MSB:`TMA_CLK_LSB]);
    match  = (cnt == refv);
    clr_wr = CTRL_WR & CTRL_WDATA[`TMA_BIT_CLEAR];
    case (clksel)
      tma_pkg::TMA_DIV1024:  tick = (pre == `TMA_PRE_1024);
      tma_pkg::TMA_DIV256:   tick = ((pre & `TMA_PRE_256) == `TMA_PRE_256);
      tma_pkg::TMA_DIV64:    tick = ((pre & `TMA_PRE_64) == `TMA_PRE_64);
      tma_pkg::TMA_DIV8:     tick = ((pre & `TMA_PRE_8) == `TMA_PRE_8);
      tma_pkg::TMA_DIV1:     tick = 1'b1;
      tma_pkg::TMA_EXT_FALL: tick = ext_fall;
      tma_pkg::TMA_EXT_RISE: tick = ext_rise;
      default:               tick = 1'b0;
    endcase
    // other capture sources are outside this block: no capture then
    cap_edge = 1'b0;
    if (!PORT_ONE_CONTROL_LOW[`TMA_P1_CAPSEL]) begin
      if (mode == tma_pkg::TMA_CAP_RISE) begin
        cap_edge = cap_rise;
      end else if (mode == tma_pkg::TMA_CAP_FALL) begin
        cap_edge = cap_fall;
      end
    end
  end

  always_comb begin
    next_pre  = pre + 10'h001;
    next_ctrl = ctrl;
    next_refv = refv;
    next_cnt  = cnt;
    next_pend = pend;
    next_tog  = tog;
    ovf_set   = 1'b0;
    mc_set    = 1'b0;
    if (CTRL_WR) begin
      next_ctrl = CTRL_WDATA & `TMA_CTRL_WMASK;
    end
    if (REF_WR) begin
      next_refv = REF_WDATA;
    end
    if (PEND_WR) begin
      next_pend = pend & PEND_WDATA;
    end
    if (OVF_ACK) begin
      next_pend[`TMA_PEND_OVF] = 1'b0;
    end
    if (tick) begin
      case (mode)
        tma_pkg::TMA_INTERVAL: begin
          if (match) begin
            next_cnt = `TMA_CNT_ZERO;
            next_tog = ~tog;
            mc_set   = 1'b1;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end
        tma_pkg::TMA_PWM: begin
          next_cnt = cnt + 8'h01;
          mc_set   = match;
          ovf_set  = (cnt == `TMA_CNT_TOP);
        end
        default: begin
          next_cnt = cnt + 8'h01;
          ovf_set  = (cnt == `TMA_CNT_TOP);
        end
      endcase
    end
    if (cap_edge) begin
      next_refv = cnt;
      mc_set    = 1'b1;
    end
    if (clr_wr) begin
      next_cnt = `TMA_CNT_ZERO;
    end
    // a new event beats a clear in the same cycle
    if (ovf_set) begin
      next_pend[`TMA_PEND_OVF] = 1'b1;
    end
    if (mc_set) begin
      next_pend[`TMA_PEND_MC] = 1'b1;
    end
    next_mode = tma_pkg::tma_mode_e'(
      next_ctrl[`TMA_MODE_MSB:`TMA_MODE_LSB]);
    next_pwm  = (next_mode == tma_pkg::TMA_PWM) &&
                (next_refv > next_cnt);
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pre  <= `TMA_PRE_RESET;
      ctrl <= `TMA_CTRL_RESET;
      refv <= `TMA_REF_RESET;
      cnt  <= `TMA_CNT_ZERO;
      pend <= `TMA_PEND_RESET;
      tog  <= 1'b0;
      pwm  <= 1'b0;
    end else begin
      pre  <= next_pre;
      ctrl <= next_ctrl;
      refv <= next_refv;
      cnt  <= next_cnt;
      pend <= next_pend;
      tog  <= next_tog;
      pwm  <= next_pwm;
    end
  end

  always_comb begin
    CTRL_RDATA        = ctrl;
    REF_RDATA         = refv;
    CNT_VALUE         = cnt;
    IRQ_PENDING       = pend;
    PWM_OUT_PIN       = pwm;
    MATCH_TOGGLE_OUT  = tog;
    OVF_IRQ           = pend[`TMA_PEND_OVF] & ctrl[`TMA_BIT_OVF_EN];
    MATCH_CAPTURE_IRQ = pend[`TMA_PEND_MC] & ctrl[`TMA_BIT_MC_EN];
    PRIORITY_LEVEL_ZERO = OVF_IRQ | MATCH_CAPTURE_IRQ;
    // overflow vector first when both ask, a fixed order
    IRQ_VECTOR = OVF_IRQ ? `TMA_VEC_OVF : `TMA_VEC_MC;
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  a_ovf_gate_off: assert property (!ctrl[0] |-> !OVF_IRQ)
    else $error("overflow request while disabled");
  a_ovf_vector: assert property (OVF_IRQ |-> PRIORITY_LEVEL_ZERO &&
      IRQ_VECTOR == 8'hD0)
    else $error("overflow vector wrong");
  a_mc_vector: assert property (MATCH_CAPTURE_IRQ && !OVF_IRQ |->
      PRIORITY_LEVEL_ZERO && IRQ_VECTOR == 8'hCE)
    else $error("match vector wrong");
  a_ovf_ack_clear: assert property (OVF_ACK && !ovf_set |=>
      !IRQ_PENDING[0])
    else $error("overflow pending not cleared by service");
  a_mc_pend_sticky: assert property (IRQ_PENDING[1] &&
      !(PEND_WR && !PEND_WDATA[1]) |=> IRQ_PENDING[1])
    else $error("match pending dropped by hardware");
  a_interval_match: assert property (mode == tma_pkg::TMA_INTERVAL &&
      tick && match && !clr_wr |=> cnt == 8'h00 &&
      MATCH_TOGGLE_OUT != $past(MATCH_TOGGLE_OUT) &&
      IRQ_PENDING[1])
    else $error("interval match misbehaved");
  a_pwm_level: assert property (mode == tma_pkg::TMA_PWM |->
      PWM_OUT_PIN == (refv > cnt))
    else $error("pwm level wrong");
  a_pwm_wrap: assert property (mode == tma_pkg::TMA_PWM && !CTRL_WR &&
      tick && cnt == 8'hFF |=> cnt == 8'h00 && IRQ_PENDING[0])
    else $error("pwm wrap wrong");
  a_capture_load: assert property (cap_edge |=>
      REF_RDATA == $past(cnt) && IRQ_PENDING[1])
    else $error("capture not loaded");
  a_capture_src: assert property (PORT_ONE_CONTROL_LOW[4] |->
      !cap_edge)
    else $error("capture taken from wrong source");
  a_clear_write: assert property (CTRL_WR && CTRL_WDATA[2] |=>
      cnt == 8'h00 && !CTRL_RDATA[2])
    else $error("counter clear write failed");
  a_counter_stop: assert property (clksel == tma_pkg::TMA_STOP &&
      !CTRL_WR |=> cnt == $past(cnt))
    else $error("stopped counter moved");

  c_interval_match: cover property (mode == tma_pkg::TMA_INTERVAL &&
      tick && match);
  c_pwm_wrap: cover property (mode == tma_pkg::TMA_PWM && tick &&
      cnt == 8'hFF);
  c_capture: cover property (cap_edge);
  c_ovf_service: cover property (IRQ_PENDING[0] && OVF_ACK);
endmodule
`default_nettype wire

// [tma_cpu_model.sv]
`default_nettype none
module tma_cpu_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       req,
  input  wire logic [7:0] vec,
  input  wire logic       en,
  input  wire logic [3:0] lat,
  output logic            ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt;
  // services the overflow vector only; match pending is left to software
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (en && req && vec === 8'hD0 && !ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      ack <= (wait_cnt >= lat);
    end else begin
      ack <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// [timer_a_interval_pwm_capture_tb_top.sv]
`default_nettype none
module timer_a_interval_pwm_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, arst_n, cwr, rwr, pwr, ack, cap, ext, svc;
  logic       oirq, mirq, lvl, pwm, tog;
  logic [7:0] cwd, rwd, p1, crd, rrd, cnt, vec, r, prev;
  logic [1:0] pwd, pend;
  logic [3:0] lat;
  int         miscompares, cmp_count, seed, i, k, last;
  int         dv[5] = '{1024, 256, 64, 8, 1};

  tma_timer tma_timer_i (.CORE_CLK(clk), .ARST_N(arst_n), .CTRL_WR(cwr),
    .CTRL_WDATA(cwd), .REF_WR(rwr), .REF_WDATA(rwd), .PEND_WR(pwr),
    .PEND_WDATA(pwd), .OVF_ACK(ack), .PORT_ONE_CONTROL_LOW(p1),
    .CAPTURE_IN_PIN(cap), .EXT_CLOCK_IN(ext), .CTRL_RDATA(crd),
    .REF_RDATA(rrd), .CNT_VALUE(cnt), .IRQ_PENDING(pend), .OVF_IRQ(oirq),
    .MATCH_CAPTURE_IRQ(mirq), .PRIORITY_LEVEL_ZERO(lvl), .IRQ_VECTOR(vec),
    .PWM_OUT_PIN(pwm), .MATCH_TOGGLE_OUT(tog));
  tma_cpu_model tma_cpu_model_i (.clk(clk), .arst_n(arst_n), .req(lvl),
    .vec(vec), .en(svc), .lat(lat), .ack(ack));

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chk1(string n, logic e, logic s);
    chk8(n, {7'h00, e}, {7'h00, s});
  endtask
  // pwm pin is high only while the reference is above the counter
  function automatic logic exp_pwm(logic [7:0] rv, logic [7:0] c);
    return rv > c;
  endfunction
  // all drivers start and end at a falling edge
  task automatic wctl(logic [7:0] d);
    cwd = d;
    cwr = 1'b1;
    cyc(1);
    cwr = 1'b0;
  endtask
  task automatic wref(logic [7:0] d);
    rwd = d;
    rwr = 1'b1;
    cyc(1);
    rwr = 1'b0;
  endtask
  task automatic clrp(logic [1:0] d);
    pwd = d;
    pwr = 1'b1;
    cyc(1);
    pwr = 1'b0;
  endtask
  task automatic waitp(int b);
    i = 0;
    while (pend[b] !== 1'b1 && i < 600) begin
      cyc(1);
      i++;
    end
    chk1("pend", 1'b1, pend[b]);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #1000000;
    miscompares++;
    end_of_test();
  end

  initial begin
    {cwr, rwr, pwr, cap, ext, svc, arst_n} = 7'h00;
    {cwd, rwd, p1, pwd, lat} = 30'h0000_0000;
    miscompares = 0;
    cmp_count = 0;
    seed = 29789;
    repeat (3) @(posedge clk);
    cyc(1);
    arst_n = 1'b1;
    chk8("ctrl", 8'h00, crd);
    chk8("pend", 8'h00, {6'h00, pend});
    chk8("vec", 8'hCE, vec);
    chk1("oirq", 1'b0, oirq);
    chk1("lvl", 1'b0, lvl);
    r = 8'h03 + 8'($random(seed) & 7);
    wref(r);
    wctl(8'h82);
    chk8("ctrl", 8'h82, crd);
    waitp(1);
    chk8("cnt", 8'h00, cnt);
    chk1("tog", 1'b1, tog);
    chk1("mirq", 1'b1, mirq);
    chk8("vec", 8'hCE, vec);
    clrp(2'h1);
    chk1("mpend", 1'b0, pend[1]);
    waitp(1);
    chk8("period", r, 8'(i));
    chk1("tog", 1'b0, tog);
    wctl(8'h80);
    cyc(20);
    chk1("mirq", 1'b0, mirq);
    chk1("mpend", 1'b1, pend[1]);
    wctl(8'h84);
    chk8("ctrl", 8'h80, crd);
    chk8("cnt", 8'h00, cnt);
    wref(8'hFF);
    for (k = 0; k < 5; k++) begin
      wctl({3'(k), 5'h04});
      cyc(4 * dv[k]);
      chk8("ticks", 8'h04, cnt);
    end
    for (k = 5; k < 8; k++) begin
      wctl({3'(k), 5'h04});
      repeat (5) begin
        ext = 1'b1;
        cyc(3);
        ext = 1'b0;
        cyc(3);
      end
      cyc(4);
      chk8("ext", k == 7 ? 8'h00 : 8'h05, cnt);
    end
    r = 8'($random(seed));
    lat = 4'($random(seed) & 7);
    wref(r);
    wctl(8'h99);
    clrp(2'h0);
    svc = 1'b1;
    last = 0;
    prev = cnt;
    for (i = 1; i < 700; i++) begin
      cyc(1);
      chk1("pwm", exp_pwm(r, cnt), pwm);
      chk8("wrap", prev + 8'h01, cnt);
      prev = cnt;
      if (oirq === 1'b1) chk8("vec", 8'hD0, vec);
      if (cnt == 8'h30) chk1("svc", 1'b0, pend[0]);
      if (cnt == 8'h00) begin
        chk1("ovf", 1'b1, pend[0]);
        chk1("oirq", 1'b1, oirq);
        chk1("lvl", 1'b1, lvl);
        if (last > 0) chk1("period", 1'b1, i - last == 256);
        last = i;
      end
    end
    svc = 1'b0;
    // the idle level is set before the mode, so mode changes never capture
    for (k = 0; k < 2; k++) begin
      cap = k[0];
      cyc(6);
      wctl(k ? 8'h92 : 8'h8A);
      clrp(2'h0);
      p1 = 8'($random(seed)) | 8'h10;
      cap = ~cap;
      cyc(6);
      chk1("nocap", 1'b0, pend[1]);
      cap = ~cap;
      cyc(6);
      p1 = 8'($random(seed)) & 8'hEF;
      cyc(3 + ($random(seed) & 15));
      cap = ~cap;
      waitp(1);
      chk8("cap", cnt - 8'h01, rrd);
      chk1("mirq", 1'b1, mirq);
      clrp(2'h1);
      cyc(8);
      chk1("once", 1'b0, pend[1]);
    end
    clrp(2'h2);
    waitp(0);
    chk1("oirq", 1'b0, oirq);
    chk1("lvl", 1'b0, lvl);
    clrp(2'h2);
    chk1("oclr", 1'b0, pend[0]);
    end_of_test();
  end
endmodule
`default_nettype wire
